// >>> core/mme_core.sv
`timescale 1ns/1ps
`default_nettype none
module mme_core
  import mme_pkg::*;
#(
  parameter int          PA_W      = 52,
  // Value is arbitrary, stands in for the version level
  parameter logic [15:0] REV_LEVEL = 16'h0010
) (
  input  wire logic            clk_sys_in,
  input  wire logic            rst_n_in,
  input  wire logic            mgmt_interrupt_in,
  input  wire logic            nmi_in,
  input  wire logic            intr_in,
  input  wire logic            init_in,
  input  wire logic            irq_enable_flag_in,
  input  wire logic            pipe_idle_in,
  input  wire logic            wbuf_empty_in,
  input  wire logic            resume_from_mgmt_in,
  input  wire logic            interrupt_return_in,
  input  wire logic [31:0]     mgmt_base_in,
  input  wire logic [63:0]     control_reg_zero_in,
  input  wire logic            msr_wr_en_in,
  input  wire logic            msr_sel_in,
  input  wire logic [63:0]     msr_wdata_in,
  input  wire logic            save_rd_en_in,
  input  wire logic [15:0]     save_rd_off_in,
  input  wire logic            acc_valid_in,
  input  wire logic [PA_W-1:0] phys_addr_in,
  output logic [63:0]          msr_rd_data_out,
  output logic [31:0]          save_rd_data_out,
  output logic                 save_rd_hit_out,
  output logic                 acc_valid_out,
  output logic                 acc_low_hit_out,
  output logic                 acc_top_hit_out,
  output logic                 acc_mgmt_ram_out,
  output logic                 fetch_stop_out,
  output logic                 mgmt_ack_out,
  output logic                 in_mgmt_mode_out,
  output logic                 entry_load_out,
  output logic                 take_nmi_out,
  output logic                 take_intr_out,
  output logic                 take_init_out,
  output logic [15:0]          cs_sel_out,
  output logic [31:0]          cs_base_out,
  output logic [31:0]          seg_limit_out,
  output logic                 seg_base_20b_out,
  output logic                 default_size_16_out,
  output logic [15:0]          data_sel_out,
  output logic [63:0]          data_base_out,
  output logic [63:0]          instr_pointer_out,
  output logic [63:0]          flags_reg_out,
  output logic [63:0]          debug_control_reg_out,
  output logic [63:0]          extended_control_reg_out,
  output logic [63:0]          extended_feature_reg_out,
  output logic [63:0]          control_reg_zero_out
);

  // ********************************************************
  // State record
  // ********************************************************
  typedef struct packed {
    mme_state_t  st;
    logic        mgmt_pend;
    logic        nmi_pend;
    logic        nmi_mask;
    logic        fetch_stop;
    logic        ack;
    logic        in_mode;
    logic        entry_load;
    logic        take_nmi;
    logic        take_intr;
    logic        take_init;
    logic        save_hit;
    logic [31:0] save_data;
    logic [15:0] cs_sel;
    logic [31:0] cs_base;
    logic [31:0] seg_limit;
    logic [15:0] data_sel;
    logic [63:0] data_base;
    logic [63:0] ip;
    logic [63:0] flags;
    logic [63:0] dbg;
    logic [63:0] xctl;
    logic [63:0] xfeat;
    logic [63:0] cr0;
    logic [63:0] base;
    logic [63:0] mask;
    logic [63:0] msr_rd;
  } mme_core_st_t;

  // Revision word fields; upper bits reserved and read as zero
  localparam logic [31:0] REV_WORD =
    (32'h1 << REV_IO_RST_BIT) | (32'h1 << REV_RELOC_BIT) | 32'(REV_LEVEL);

  mme_core_st_t q_ff;
  mme_core_st_t nxt_q;
  logic         mgmt_go;
  logic         nmi_ok;
  logic         nmi_go;
  logic         intr_go;
  logic         init_go;

  // ********************************************************
  // Next-state logic
  // ********************************************************
  // Sequencer, interrupt arbitration and register file in one pass
  always_comb begin
    nxt_q            = q_ff;
    nxt_q.ack        = 1'b0;
    nxt_q.entry_load = 1'b0;

    mgmt_go = (q_ff.st == MME_IDLE) && (q_ff.mgmt_pend || mgmt_interrupt_in);

    // NMI masked in management mode until interrupt return
    nmi_ok = ((q_ff.st == MME_IDLE) && !mgmt_go) ||
             ((q_ff.st == MME_MGMT) && !q_ff.nmi_mask);
    nmi_go = (q_ff.nmi_pend || nmi_in) && nmi_ok;

    // maskable requests obey the flag software restores
    intr_go = intr_in && irq_enable_flag_in && !nmi_go && !mgmt_go &&
              ((q_ff.st == MME_IDLE) || (q_ff.st == MME_MGMT));

    // INIT dropped anywhere but normal execution
    init_go = init_in && (q_ff.st == MME_IDLE) && !mgmt_go;

    // requests during entry or handler are held, clear beats set
    if (mgmt_go) begin
      nxt_q.mgmt_pend = 1'b0;
    end else begin
      nxt_q.mgmt_pend = q_ff.mgmt_pend || mgmt_interrupt_in;
    end

    // latched NMI waits for the resume or interrupt return, then goes ahead of INTR but behind a management request
    if (nmi_go) begin
      nxt_q.nmi_pend = 1'b0;
    end else begin
      nxt_q.nmi_pend = q_ff.nmi_pend || nmi_in;
    end

    nxt_q.take_nmi  = nmi_go;
    nxt_q.take_intr = intr_go;
    nxt_q.take_init = init_go;

    unique case (q_ff.st)
      MME_IDLE: begin
        if (mgmt_go) begin
          nxt_q.st = MME_DRAIN;
        end
      end
      MME_DRAIN: begin
        // wait for retire and write drain before acknowledging
        if (pipe_idle_in && wbuf_empty_in) begin
          nxt_q.ack = 1'b1;
          nxt_q.st  = MME_ENTER;
        end
      end
      MME_ENTER: begin
        nxt_q.st         = MME_MGMT;
        nxt_q.entry_load = 1'b1;
        nxt_q.nmi_mask   = 1'b1;
        // code segment from the relocatable base
        nxt_q.cs_sel     = mgmt_base_in[CS_SEL_SHIFT +: 16];
        nxt_q.cs_base    = mgmt_base_in;
        // flat 4 Gbyte limit for all segments
        nxt_q.seg_limit  = SEG_LIMIT_INIT;
        nxt_q.ip         = IP_INIT;
        nxt_q.xctl       = XCTL_INIT;
        nxt_q.xfeat      = XFEAT_INIT;
        nxt_q.data_sel   = DATA_SEL_INIT;
        nxt_q.data_base  = DATA_BASE_INIT;
        // flags value leaves the interrupt enable clear
        nxt_q.flags      = FLAGS_INIT;
        // debug control with all trap enables off
        nxt_q.dbg        = DBG_CTL_INIT;
        // drop only the four mode bits
        nxt_q.cr0        = control_reg_zero_in & ~CR0_CLR_MASK;
      end
      MME_MGMT: begin
        // interrupt return lifts the NMI mask
        if (interrupt_return_in) begin
          nxt_q.nmi_mask = 1'b0;
        end
        // held requests are taken from idle after the resume
        if (resume_from_mgmt_in) begin
          nxt_q.st       = MME_IDLE;
          nxt_q.nmi_mask = 1'b0;
        end
      end
    endcase

    // Fetch stays stopped exactly while draining
    nxt_q.fetch_stop = (nxt_q.st == MME_DRAIN);
    // real-mode style bases and sizes track the mode flag
    nxt_q.in_mode    = (nxt_q.st == MME_MGMT);

    // Window registers: only implemented bits are kept
    if (msr_wr_en_in && msr_sel_in == MSR_SEL_BASE) begin
      nxt_q.base = msr_wdata_in & BASE_WR_MASK;
    end
    if (msr_wr_en_in && msr_sel_in == MSR_SEL_MASK) begin
      nxt_q.mask = msr_wdata_in & MASK_WR_MASK;
    end
    nxt_q.msr_rd = (msr_sel_in == MSR_SEL_MASK) ? q_ff.mask : q_ff.base;

    // read-only word, no write path exists
    nxt_q.save_hit  = save_rd_en_in && (save_rd_off_in == REV_OFFSET);
    nxt_q.save_data = nxt_q.save_hit ? REV_WORD : 32'h0000_0000;
  end

  // ********************************************************
  // State register
  // ********************************************************
  // Reset leaves every field zero, idle and unmasked
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      q_ff      <= '0;
      q_ff.base <= BASE_RST;
      q_ff.mask <= MASK_RST;
    end else begin
      q_ff <= nxt_q;
    end
  end

  // ********************************************************
  // Window decoder
  // ********************************************************
  // Decoder sees the registered window so a write lands one cycle later
  mme_win_decode #(
    .PA_W (PA_W)
  ) u_win_decode (
    .clk_sys_in    (clk_sys_in),
    .rst_n_in      (rst_n_in),
    .acc_valid_in  (acc_valid_in),
    .phys_addr_in  (phys_addr_in),
    .in_mode_in    (q_ff.in_mode),
    .win_base_in   (q_ff.base),
    .win_mask_in   (q_ff.mask),
    .hit_valid_out (acc_valid_out),
    .low_hit_out   (acc_low_hit_out),
    .top_hit_out   (acc_top_hit_out),
    .mgmt_ram_out  (acc_mgmt_ram_out)
  );

  // ********************************************************
  // Outputs
  // ********************************************************
  assign msr_rd_data_out          = q_ff.msr_rd;
  assign save_rd_data_out         = q_ff.save_data;
  assign save_rd_hit_out          = q_ff.save_hit;
  assign fetch_stop_out           = q_ff.fetch_stop;
  assign mgmt_ack_out             = q_ff.ack;
  assign in_mgmt_mode_out         = q_ff.in_mode;
  assign entry_load_out           = q_ff.entry_load;
  assign take_nmi_out             = q_ff.take_nmi;
  assign take_intr_out            = q_ff.take_intr;
  assign take_init_out            = q_ff.take_init;
  assign cs_sel_out               = q_ff.cs_sel;
  assign cs_base_out              = q_ff.cs_base;
  assign seg_limit_out            = q_ff.seg_limit;
  assign seg_base_20b_out         = q_ff.in_mode;
  assign default_size_16_out      = q_ff.in_mode;
  assign data_sel_out             = q_ff.data_sel;
  assign data_base_out            = q_ff.data_base;
  assign instr_pointer_out        = q_ff.ip;
  assign flags_reg_out            = q_ff.flags;
  assign debug_control_reg_out    = q_ff.dbg;
  assign extended_control_reg_out = q_ff.xctl;
  assign extended_feature_reg_out = q_ff.xfeat;
  assign control_reg_zero_out     = q_ff.cr0;

  // ********************************************************
  // Checks
  // ********************************************************
  chk_ack_after_drain: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    mgmt_ack_out |-> $past(fetch_stop_out) && $past(pipe_idle_in && wbuf_empty_in))
    else $error("acknowledge before drain finished");

  chk_ack_single_pulse: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    mgmt_ack_out |=> !mgmt_ack_out && entry_load_out)
    else $error("acknowledge not a single pulse before entry");

  chk_mgmt_beats_nmi: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (q_ff.st == MME_IDLE) && mgmt_interrupt_in |=> !take_nmi_out && fetch_stop_out)
    else $error("NMI taken over management interrupt");

  chk_latched_reentry: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (q_ff.st == MME_MGMT) && resume_from_mgmt_in && q_ff.mgmt_pend
    |=> !in_mgmt_mode_out ##1 fetch_stop_out)
    else $error("latched management interrupt not taken after exit");

  chk_entry_code_seg: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    entry_load_out |-> cs_sel_out == cs_base_out[19:4] &&
                       seg_limit_out == 32'hFFFF_FFFF)
    else $error("code segment entry values wrong");

  chk_entry_values: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    entry_load_out |-> instr_pointer_out == 64'h8000 &&
      flags_reg_out == 64'h2 && debug_control_reg_out == 64'h400 &&
      extended_feature_reg_out == 64'h0 && data_sel_out == 16'h0)
    else $error("entry register values wrong");

  chk_cr0_bits: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    entry_load_out |-> control_reg_zero_out ==
      ($past(control_reg_zero_in) & 64'hFFFF_FFFF_7FFF_FFF2))
    else $error("control register zero entry value wrong");

  chk_init_ignored: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    in_mgmt_mode_out |=> !take_init_out)
    else $error("INIT taken in management mode");

  chk_nmi_masked: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    entry_load_out && !interrupt_return_in |=> !take_nmi_out)
    else $error("NMI taken while masked on entry");

  chk_nmi_after_resume: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (q_ff.st == MME_MGMT) && resume_from_mgmt_in && q_ff.nmi_pend &&
    !q_ff.mgmt_pend && !mgmt_interrupt_in |=> ##1 take_nmi_out)
    else $error("latched NMI not delivered after resume");

  chk_rev_word: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    save_rd_en_in && save_rd_off_in == 16'hFEFC
    |=> save_rd_hit_out && save_rd_data_out[17:16] == 2'b11 &&
        save_rd_data_out[31:18] == 14'h0)
    else $error("revision word capability bits wrong");

endmodule
`default_nettype wire

// >>> core/mme_pkg.sv
package mme_pkg;

  // ********************************************************
  // Address decode
  // ********************************************************
  localparam int          PA_W_MAX        = 52;
  localparam int          TOP_LSB         = 17;
  localparam logic [51:0] LOW_WIN_LO      = 52'h0_0000_000A_0000;
  localparam logic [51:0] LOW_WIN_HI      = 52'h0_0000_000B_FFFF;
  localparam int          MASK_LOW_EN_BIT = 0;
  localparam int          MASK_TOP_EN_BIT = 1;

  // ********************************************************
  // Window registers
  // ********************************************************
  localparam logic        MSR_SEL_BASE    = 1'b0;
  localparam logic        MSR_SEL_MASK    = 1'b1;
  localparam logic [63:0] BASE_WR_MASK    = 64'h000F_FFFF_FFFE_0000;
  localparam logic [63:0] MASK_WR_MASK    = 64'h000F_FFFF_FFFE_0003;
  localparam logic [63:0] BASE_RST        = 64'h0000_0000_0000_0000;
  localparam logic [63:0] MASK_RST        = 64'h0000_0000_0000_0000;

  // ********************************************************
  // Save area revision word
  // ********************************************************
  localparam logic [15:0] REV_OFFSET      = 16'hFEFC;
  localparam int          REV_IO_RST_BIT  = 16;
  localparam int          REV_RELOC_BIT   = 17;

  // ********************************************************
  // Entry state
  // ********************************************************
  localparam int          CS_SEL_SHIFT    = 4;
  localparam logic [31:0] SEG_LIMIT_INIT  = 32'hFFFF_FFFF;
  localparam logic [63:0] IP_INIT         = 64'h0000_0000_0000_8000;
  localparam logic [63:0] FLAGS_INIT      = 64'h0000_0000_0000_0002;
  localparam logic [63:0] DBG_CTL_INIT    = 64'h0000_0000_0000_0400;
  localparam logic [63:0] XCTL_INIT       = 64'h0000_0000_0000_0000;
  localparam logic [63:0] XFEAT_INIT      = 64'h0000_0000_0000_0000;
  localparam logic [15:0] DATA_SEL_INIT   = 16'h0000;
  localparam logic [63:0] DATA_BASE_INIT  = 64'h0000_0000_0000_0000;
  // Protection enable 0, emulation 2, task switched 3, paging 31
  localparam logic [63:0] CR0_CLR_MASK    = 64'h0000_0000_8000_000D;

  // ********************************************************
  // Sequencer states
  // ********************************************************
  typedef enum logic [1:0] {
    MME_IDLE  = 2'b00,
    MME_DRAIN = 2'b01,
    MME_ENTER = 2'b10,
    MME_MGMT  = 2'b11
  } mme_state_t;

endpackage

// >>> core/mme_win_decode.sv
`timescale 1ns/1ps
`default_nettype none
module mme_win_decode
  import mme_pkg::*;
#(
  parameter int PA_W = 52
) (
  input  wire logic            clk_sys_in,
  input  wire logic            rst_n_in,
  input  wire logic            acc_valid_in,
  input  wire logic [PA_W-1:0] phys_addr_in,
  input  wire logic            in_mode_in,
  input  wire logic [63:0]     win_base_in,
  input  wire logic [63:0]     win_mask_in,
  output logic                 hit_valid_out,
  output logic                 low_hit_out,
  output logic                 top_hit_out,
  output logic                 mgmt_ram_out
);

  // ********************************************************
  // Parameter check
  // ********************************************************
  if (PA_W < 18 || PA_W > PA_W_MAX) begin : g_bad_pa
    $error("mme_win_decode: PA_W out of range");
  end

  typedef struct packed {
    logic vld;
    logic low;
    logic top;
    logic ram;
  } mme_dec_st_t;

  mme_dec_st_t q_ff;
  mme_dec_st_t nxt_q;
  logic [51:0] pa;
  logic        low_hit;
  logic        top_hit;
  logic        protect;

  // Address widened so narrower physical buses compare cleanly
  always_comb begin
    pa = 52'(phys_addr_in);
    low_hit = (pa >= LOW_WIN_LO) && (pa <= LOW_WIN_HI);
    top_hit = ((pa[51:TOP_LSB] & win_mask_in[51:TOP_LSB]) ==
               (win_base_in[51:TOP_LSB] & win_mask_in[51:TOP_LSB]));
    protect = (low_hit && win_mask_in[MASK_LOW_EN_BIT]) ||
              (top_hit && win_mask_in[MASK_TOP_EN_BIT]);
    nxt_q     = q_ff;
    nxt_q.vld = acc_valid_in;
    nxt_q.low = acc_valid_in && low_hit;
    nxt_q.top = acc_valid_in && top_hit;
    // only management mode reaches the protected RAM
    nxt_q.ram = acc_valid_in && protect && in_mode_in;
  end

  // One register stage: the hit shows one cycle after the request
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign hit_valid_out = q_ff.vld;
  assign low_hit_out   = q_ff.low;
  assign top_hit_out   = q_ff.top;
  assign mgmt_ram_out  = q_ff.ram;

  // ********************************************************
  // Checks
  // ********************************************************
  chk_low_range: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    acc_valid_in && 52'(phys_addr_in) == LOW_WIN_LO |=> low_hit_out)
    else $error("low window base not decoded");
  chk_no_outside_ram: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    acc_valid_in && !in_mode_in |=> !mgmt_ram_out)
    else $error("outside access reached management RAM");

endmodule
`default_nettype wire

// >>> verif/mgmt_mode_entry_and_mgmt_ram_decode_tb.sv
`timescale 1ns/1ps
`default_nettype none
module mgmt_mode_entry_and_mgmt_ram_decode_tb;
  localparam logic [15:0] REV_T = 16'h0A5C; // Arbitrary version level
  logic clk_sys_in, rst_n_in, go, nmi_in, intr_in, init_in;
  logic mgmt_interrupt_in, irq_enable_flag_in, pipe_idle_in;
  logic wbuf_empty_in, resume_from_mgmt_in, interrupt_return_in;
  logic msr_wr_en_in, msr_sel_in, save_rd_en_in, acc_valid_in;
  logic save_rd_hit_out, acc_valid_out, acc_low_hit_out;
  logic acc_top_hit_out, acc_mgmt_ram_out, fetch_stop_out;
  logic mgmt_ack_out, in_mgmt_mode_out, entry_load_out, take_nmi_out;
  logic take_intr_out, take_init_out, seg_base_20b_out;
  logic default_size_16_out;
  logic [3:0]  dly;
  logic [15:0] save_rd_off_in, cs_sel_out, data_sel_out;
  logic [31:0] mgmt_base_in, save_rd_data_out, cs_base_out, seg_limit_out;
  logic [51:0] phys_addr_in;
  logic [63:0] control_reg_zero_in, msr_wdata_in, msr_rd_data_out;
  logic [63:0] data_base_out, instr_pointer_out, flags_reg_out;
  logic [63:0] debug_control_reg_out, extended_control_reg_out;
  logic [63:0] extended_feature_reg_out, control_reg_zero_out;
  int          fails, cmp_count, cyc;

  mme_core #(.PA_W(52), .REV_LEVEL(REV_T)) dut (.*);
  mme_sys_model sysm (.clk_sys_in, .rst_n_in, .go_in(go), .dly_in(dly),
    .mgmt_interrupt_out(mgmt_interrupt_in));

  // Free-running clock and a hang guard well past the expected run
  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 2000) begin
      fails++;
      close_out;
    end
  end

  task tk;
    @(negedge clk_sys_in);
  endtask
  task ck(input logic [127:0] got, input logic [127:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task close_out;
    $display("fails=%0d cmp_count=%0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task wr(input logic s, input logic [63:0] d, input logic [63:0] e);
    msr_wr_en_in = 1'b1;
    msr_sel_in = s;
    msr_wdata_in = d;
    tk;
    msr_wr_en_in = 1'b0;
    tk;
    ck(msr_rd_data_out, e);
  endtask
  task acc(input logic [51:0] a, input logic [2:0] m, input logic [2:0] e);
    acc_valid_in = 1'b1;
    phys_addr_in = a;
    tk;
    acc_valid_in = 1'b0;
    ck({acc_valid_out, {acc_low_hit_out, acc_top_hit_out,
        acc_mgmt_ram_out} & m}, {1'b1, e});
    // Let an edge pass so back-to-back calls never re-raise valid at once
    tk;
  endtask
  // Entry with a drain that stalls first on the pipe, then on writes
  task enter(input logic [31:0] b, input logic [15:0] s);
    int i;
    mgmt_base_in = b;
    for (i = 0; i < 12 && fetch_stop_out !== 1'b1; i++) tk;
    ck(fetch_stop_out, 1);
    for (i = 0; i < 4; i++) begin
      pipe_idle_in = i[1];
      wbuf_empty_in = !i[1];
      tk;
      ck({mgmt_ack_out, fetch_stop_out}, 2'b01);
    end
    pipe_idle_in = 1'b1;
    wbuf_empty_in = 1'b1;
    tk;
    ck({mgmt_ack_out, fetch_stop_out}, 2'b10);
    pipe_idle_in = 1'b0;
    tk;
    ck({mgmt_ack_out, entry_load_out, in_mgmt_mode_out}, 3'b011);
    ck({cs_sel_out, cs_base_out, seg_limit_out}, {s, b, 32'hFFFF_FFFF});
    ck({seg_base_20b_out, default_size_16_out, data_sel_out, data_base_out},
       {2'b11, 80'h0});
    ck({instr_pointer_out, flags_reg_out}, {64'h8000, 64'h2});
    ck({debug_control_reg_out, extended_control_reg_out},
       {64'h400, 64'h0});
    ck({extended_feature_reg_out, control_reg_zero_out},
       {64'h0, 64'hFFFF_FFFF_7FFF_FFF2});
  endtask
  task t_rev;
    save_rd_en_in = 1'b1;
    save_rd_off_in = 16'hFEFC;
    tk;
    ck({save_rd_hit_out, save_rd_data_out},
       {1'b1, 14'h0000, 2'b11, REV_T});
    save_rd_off_in = 16'hFEF8;
    {init_in, intr_in, irq_enable_flag_in} = 3'b111;
    tk;
    {save_rd_en_in, init_in, intr_in} = 3'b000;
    ck({save_rd_hit_out, save_rd_data_out, take_init_out, take_intr_out},
       3);
  endtask
  // Windows kept aligned, at least 128 Kbyte and apart
  task t_win;
    ck(msr_rd_data_out, 0);
    wr(1'b0, 64'h0010_0000, 64'h0010_0000);
    wr(1'b1, 64'hFFFF_FFFF_FFFC_0003, 64'h000F_FFFF_FFFC_0003);
    acc(52'hA_0000, 3'b111, 3'b100);
    acc(52'hB_FFFF, 3'b111, 3'b100);
    acc(52'h9_FFFF, 3'b111, 3'b000);
    acc(52'hC_0000, 3'b111, 3'b000);
    acc(52'h10_0000, 3'b111, 3'b010);
    acc(52'h13_FFFF, 3'b111, 3'b010);
    acc(52'h14_0000, 3'b111, 3'b000);
  endtask
  task t_mode;
    int i;
    go = 1'b1;
    tk;
    go = 1'b0;
    enter(32'h000A_0000, 16'hA000);
    acc(52'hA_0000, 3'b111, 3'b101);
    acc(52'h10_0000, 3'b111, 3'b011);
    wr(1'b1, 64'h000F_FFFF_FFFC_0002, 64'h000F_FFFF_FFFC_0002);
    acc(52'hA_0000, 3'b001, 3'b000);
    acc(52'h10_0000, 3'b001, 3'b001);
    {nmi_in, init_in, go, dly} = 7'h70;
    tk;
    {nmi_in, init_in, go} = 3'b000;
    for (i = 0; i < 4; i++) begin
      tk;
      ck({take_nmi_out, take_init_out, fetch_stop_out}, 0);
    end
    resume_from_mgmt_in = 1'b1;
    tk;
    resume_from_mgmt_in = 1'b0;
    ck(in_mgmt_mode_out, 0);
    tk;
    ck({fetch_stop_out, take_nmi_out}, 2'b10);
    enter(32'h0003_0000, 16'h3000);
    for (i = 0; i < 3; i++) begin
      tk;
      ck(take_nmi_out, 0);
    end
    interrupt_return_in = 1'b1;
    tk;
    interrupt_return_in = 1'b0;
    for (i = 0; i < 3 && take_nmi_out !== 1'b1; i++) tk;
    ck(take_nmi_out, 1);
    nmi_in = 1'b1;
    tk;
    nmi_in = 1'b0;
    for (i = 0; i < 3 && take_nmi_out !== 1'b1; i++) tk;
    ck(take_nmi_out, 1);
    resume_from_mgmt_in = 1'b1;
    tk;
    resume_from_mgmt_in = 1'b0;
    tk;
    ck({in_mgmt_mode_out, fetch_stop_out, take_nmi_out}, 0);
  endtask
  // All three requests land on one edge in idle
  task t_prio;
    go = 1'b1;
    tk;
    go = 1'b0;
    tk;
    {nmi_in, intr_in, irq_enable_flag_in} = 3'b111;
    tk;
    {nmi_in, intr_in} = 2'b00;
    ck({fetch_stop_out, take_nmi_out, take_intr_out}, 3'b100);
    // The NMI latched behind the entry must follow the resume at once
    enter(32'h0003_0000, 16'h3000);
    resume_from_mgmt_in = 1'b1;
    tk;
    resume_from_mgmt_in = 1'b0;
    tk;
    ck({in_mgmt_mode_out, take_nmi_out}, 2'b01);
  endtask

  initial begin
    {rst_n_in, go, dly, nmi_in, intr_in, init_in, irq_enable_flag_in} = '0;
    {pipe_idle_in, wbuf_empty_in, resume_from_mgmt_in} = '0;
    {interrupt_return_in, msr_wr_en_in, msr_sel_in, save_rd_en_in} = '0;
    {acc_valid_in, save_rd_off_in, mgmt_base_in, phys_addr_in} = '0;
    msr_wdata_in = '0;
    control_reg_zero_in = '1;
    dly = 4'h5;
    repeat (20) tk;
    rst_n_in = 1'b1;
    tk;
    t_rev;
    t_win;
    t_mode;
    t_prio;
    close_out;
  end
endmodule
`default_nettype wire

// >>> verif/mme_sys_model.sv
`timescale 1ns/1ps
`default_nettype none
// System logic that raises one management interrupt pulse per request
module mme_sys_model (
  input  wire logic       clk_sys_in,
  input  wire logic       rst_n_in,
  input  wire logic       go_in,
  input  wire logic [3:0] dly_in,
  output logic            mgmt_interrupt_out
);
  logic [4:0] cnt_ff;
  // Countdown gives a prompt or a slow request; never a held level
  always_ff @(posedge clk_sys_in) begin
    mgmt_interrupt_out <= rst_n_in && cnt_ff == 5'h01;
    if (!rst_n_in)
      cnt_ff <= 5'h00;
    else if (go_in)
      cnt_ff <= {1'b0, dly_in} + 5'h01;
    else if (cnt_ff != 5'h00)
      cnt_ff <= cnt_ff - 5'h01;
  end
endmodule
`default_nettype wire
